// >>> logic/occ_map.svh
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH

// ------------------------------------------------------------
// Register indices on the plain register port
// ------------------------------------------------------------
`define OCC_ADDR_W        2
`define OCC_IDX_CONTROL   2'h0
`define OCC_IDX_PRIMARY   2'h1
`define OCC_IDX_SECONDARY 2'h2
`define OCC_IDX_STATUS    2'h3

// ------------------------------------------------------------
// Control and status register fields
// ------------------------------------------------------------
`define OCC_MODE_LSB      0
`define OCC_MODE_MSB      2
`define OCC_TSEL_BIT      3
`define OCC_FLT_BIT       4
`define OCC_SIDL_BIT      13
`define OCC_STAT_FLAG_BIT 0

// ------------------------------------------------------------
// Compare mode codes
// ------------------------------------------------------------
`define OCC_MODE_OFF      3'h0
`define OCC_MODE_LOW      3'h1
`define OCC_MODE_HIGH     3'h2
`define OCC_MODE_TOGGLE   3'h3
`define OCC_MODE_ONESHOT  3'h4
`define OCC_MODE_CONT     3'h5
`define OCC_MODE_PWM      3'h6
`define OCC_MODE_PWM_FLT  3'h7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define OCC_RST_WORD      16'h0000

`endif

// >>> logic/occ_pkg.sv
package occ_pkg;

  // ------------------------------------------------------------
  // Timebase view seen by the channel
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic        inc;
    logic        run;
    logic        stop_idle;
  } occ_tb_t;

  // ------------------------------------------------------------
  // Whole channel state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  mode;
    logic        tsel;
    logic        flt;
    logic        sidl;
    logic [15:0] pri;
    logic [15:0] sec;
    logic        out;
    logic        oe;
    logic        flag;
    logic        done;
    logic        fsync1;
    logic        fsync2;
    logic        pevt;
    logic [15:0] rdata;
  } occ_state_t;

endpackage

// >>> logic/occ_channel.sv
`timescale 1ns/1ns
`include "occ_map.svh"

module occ_channel #(
  parameter int WIDTH = 16
) (
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire logic [`OCC_ADDR_W-1:0] addr,
  input  wire logic [15:0]            wdata,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output logic      [15:0]            rdata_q,
  input  wire occ_pkg::occ_tb_t       tb_first,
  input  wire occ_pkg::occ_tb_t       tb_second,
  input  wire logic                   cpu_sleep,
  input  wire logic                   cpu_idle,
  input  wire logic                   fault_input,
  output logic                        cmp_out_q,
  output logic                        cmp_oe_q,
  output logic                        chan_flag_q,
  output logic                        pwm_period_evt_q
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (WIDTH != 16) begin : g_width_check
    $error("occ_channel supports only WIDTH of 16");
  end

  occ_pkg::occ_state_t s_q;
  occ_pkg::occ_state_t s_d;
  occ_pkg::occ_tb_t    tb;
  logic                act;
  logic                pwm;
  logic                match_p;
  logic                match_s;
  logic                wrap;
  logic                wr_ctl;
  logic [15:0]         ctl_word;

  // ------------------------------------------------------------
  // Timebase selection and event decode
  // ------------------------------------------------------------
  always_comb begin
    tb = s_q.tsel ? tb_second : tb_first;
    // Idle keeps running only with both stop bits clear.
    act = !cpu_sleep &&
          (!cpu_idle || (!s_q.sidl && tb.run && !tb.stop_idle));
    pwm = s_q.mode[2] && s_q.mode[1];
    match_p = act && tb.inc && (tb.count == s_q.pri);
    match_s = act && tb.inc && (tb.count == s_q.sec);
    // A fresh zero after an increment is the period rollover.
    wrap = act && tb.inc && (tb.count == 16'h0000);
    wr_ctl = wr_en && (addr == `OCC_IDX_CONTROL);
    ctl_word = 16'h0000;
    ctl_word[`OCC_MODE_MSB:`OCC_MODE_LSB] = s_q.mode;
    ctl_word[`OCC_TSEL_BIT] = s_q.tsel;
    ctl_word[`OCC_FLT_BIT] = s_q.flt;
    ctl_word[`OCC_SIDL_BIT] = s_q.sidl;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [15:0] new_pri;
    logic        clr_flag;
    s_d = s_q;
    new_pri = s_q.pri;
    clr_flag = 1'b0;
    s_d.fsync1 = fault_input;
    s_d.fsync2 = s_q.fsync1;
    s_d.pevt = 1'b0;
    s_d.rdata = 16'h0000;

    if (rd_en) begin
      unique case (addr)
        `OCC_IDX_CONTROL:   s_d.rdata = ctl_word;
        `OCC_IDX_PRIMARY:   s_d.rdata = s_q.pri;
        `OCC_IDX_SECONDARY: s_d.rdata = s_q.sec;
        `OCC_IDX_STATUS: begin
          s_d.rdata[`OCC_STAT_FLAG_BIT] = s_q.flag;
        end
      endcase
    end

    // Sleep stops compare and flag actions; register writes still land and the pin keeps its level.
    if (!cpu_sleep) begin
      unique case (s_q.mode)
        `OCC_MODE_LOW: begin
          // Wrapping without a match simply changes nothing.
          if (match_p) s_d.out = 1'b0;
        end
        `OCC_MODE_HIGH: begin
          if (match_p) s_d.out = 1'b1;
        end
        `OCC_MODE_TOGGLE: begin
          if (match_p) s_d.out = !s_q.out;
        end
        `OCC_MODE_ONESHOT, `OCC_MODE_CONT: begin
          if (!s_q.done) begin
            if (match_p) s_d.out = 1'b1;
            if (match_s && s_q.out) begin
              s_d.out = 1'b0;
              s_d.done = (s_q.mode == `OCC_MODE_ONESHOT);
            end
          end
        end
        `OCC_MODE_PWM, `OCC_MODE_PWM_FLT: begin
          if (wrap) begin
            new_pri = s_q.sec;
            s_d.pri = s_q.sec;
            s_d.out = (s_q.sec != 16'h0000);
            s_d.pevt = 1'b1;
          end
          // A duty beyond the period never matches, so stays high.
          if (act && tb.inc && tb.count == new_pri) begin
            s_d.out = 1'b0;
          end
          if (s_q.mode == `OCC_MODE_PWM_FLT && !s_q.fsync2) begin
            s_d.flt = 1'b1;
          end
        end
        `OCC_MODE_OFF: begin
          s_d.out = 1'b0;
        end
      endcase
      if (!pwm && s_q.mode != `OCC_MODE_OFF &&
          (match_p || (s_q.mode[2] && match_s))) begin
        s_d.flag = 1'b1;
      end
    end

    if (wr_en) begin
      unique case (addr)
        `OCC_IDX_CONTROL: begin
          s_d.mode = wdata[`OCC_MODE_MSB:`OCC_MODE_LSB];
          s_d.tsel = wdata[`OCC_TSEL_BIT];
          s_d.sidl = wdata[`OCC_SIDL_BIT];
          s_d.done = 1'b0;
          // The fault holds until control is rewritten to a non-fault mode, or to PWM with fault once the input is high.
          if (s_d.mode == `OCC_MODE_PWM_FLT && s_q.fsync2) begin
            s_d.flt = 1'b0;
          end else if (s_d.mode != `OCC_MODE_PWM_FLT) begin
            s_d.flt = 1'b0;
          end
        end
        `OCC_IDX_PRIMARY: begin
          if (!pwm) s_d.pri = wdata;
        end
        `OCC_IDX_SECONDARY: s_d.sec = wdata;
        `OCC_IDX_STATUS: clr_flag = wdata[`OCC_STAT_FLAG_BIT];
      endcase
    end

    // A compare event in the clearing cycle survives the clear only when the flag was not already set.
    if (clr_flag && !(s_d.flag && !s_q.flag)) s_d.flag = 1'b0;

    s_d.oe = (s_d.mode != `OCC_MODE_OFF) && !s_d.flt;
    if (cpu_sleep) s_d.oe = s_q.oe;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_q          = s_q.rdata;
  assign cmp_out_q        = s_q.out;
  assign cmp_oe_q         = s_q.oe;
  assign chan_flag_q      = s_q.flag;
  assign pwm_period_evt_q = s_q.pevt;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  mode_off_a: assert property (
    (s_q.mode == `OCC_MODE_OFF) |-> !cmp_oe_q)
    else $error("pin driven while disabled");

  force_low_a: assert property (
    (s_q.mode == `OCC_MODE_LOW && match_p && !cpu_sleep) |=> !cmp_out_q)
    else $error("force low failed");

  toggle_pin_a: assert property (
    (s_q.mode == `OCC_MODE_TOGGLE && match_p && !cpu_sleep && !wr_en)
    |=> (cmp_out_q != $past(cmp_out_q)))
    else $error("toggle failed");

  sleep_hold_a: assert property (
    cpu_sleep |=> ($stable(cmp_out_q) && $stable(cmp_oe_q)))
    else $error("pin moved in sleep");

  duty_latch_a: assert property (
    (pwm && wrap && !wr_en) |=>
    (s_q.pri == $past(s_q.sec) && pwm_period_evt_q))
    else $error("duty not latched at wrap");

  duty_zero_a: assert property (
    (pwm && wrap && s_q.sec == 16'h0000) |=> !cmp_out_q)
    else $error("zero duty drove high");

  fault_tri_a: assert property (
    (s_q.mode == `OCC_MODE_PWM_FLT && !s_q.fsync2 && !cpu_sleep && !wr_en)
    |=> (!cmp_oe_q && s_q.flt))
    else $error("fault did not tri-state");

  fault_hold_a: assert property (
    (s_q.flt && !wr_ctl) |=> s_q.flt)
    else $error("fault cleared without rewrite");

  pwm_no_flag_a: assert property (
    (pwm && !s_q.flag && !wr_en) |=> !chan_flag_q)
    else $error("channel flag set in PWM");

  oneshot_once_a: assert property (
    (s_q.mode == `OCC_MODE_ONESHOT && s_q.done && !wr_en)
    |=> $stable(cmp_out_q))
    else $error("second pulse in one-shot");

  cov_pwm_wrap: cover property (pwm && wrap && s_q.sec != 16'h0000);
  cov_fault: cover property (s_q.flt ##1 !s_q.flt);
  cov_pulse: cover property (
    s_q.mode == `OCC_MODE_CONT && cmp_out_q ##[1:300] !cmp_out_q);

endmodule

// >>> dv/occ_load.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Load hung on the compare pin
// ------------------------------------------------------------
module occ_load (
  input  wire logic drive,
  input  wire logic enable,
  input  wire logic trip,
  output logic      pin,
  output logic      fault_input
);
  // A pull-up holds the pin high whenever the channel lets it float.
  assign pin = enable ? drive : 1'b1;
  // The load pulls its fault line low only while it is tripped.
  assign fault_input = !trip;
endmodule

// >>> dv/test_output_compare_pwm_channel.sv
`timescale 1ns/1ns
`include "occ_map.svh"
module test_output_compare_pwm_channel;
  logic             clock;
  logic             rst_b = 1'b0;
  logic             wr_en = 1'b0;
  logic             rd_en = 1'b0;
  logic             cpu_sleep = 1'b0;
  logic             cpu_idle = 1'b0;
  logic             trip = 1'b0;
  logic [1:0]       addr = 2'h0;
  logic [15:0]      wdata = 16'h0000;
  logic [15:0]      rdata_q;
  logic [15:0]      p;
  logic [15:0]      q;
  logic             t;
  logic             cmp_out_q;
  logic             cmp_oe_q;
  logic             chan_flag_q;
  logic             pwm_evt;
  logic             pin;
  logic             fault_input;
  occ_pkg::occ_tb_t tbs [2] = '{default: 19'h00002};
  int               mismatches = 0;
  int               checked = 0;
  int               pulses = 0;
  int               want_p = 0;

  // ------------------------------------------------------------
  // Clock, design and load
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  occ_channel occ_channel_i (.clock(clock), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
    .tb_first(tbs[0]), .tb_second(tbs[1]), .cpu_sleep(cpu_sleep),
    .cpu_idle(cpu_idle), .fault_input(fault_input),
    .cmp_out_q(cmp_out_q), .cmp_oe_q(cmp_oe_q),
    .chan_flag_q(chan_flag_q), .pwm_period_evt_q(pwm_evt));
  occ_load occ_load_i (.drive(cmp_out_q), .enable(cmp_oe_q), .trip(trip),
    .pin(pin), .fault_input(fault_input));
  always @(posedge clock) begin
    if (pwm_evt === 1'b1) begin
      pulses++;
    end
  end

  // ------------------------------------------------------------
  // Bus cycles and checks
  // ------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] want);
    checked++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [15:0] want);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    cmp(rdata_q, want);
  endtask
  task automatic ctl(input logic [2:0] m, input logic s, input logic i);
    wr(`OCC_IDX_CONTROL, {2'h0, i, 8'h00, 1'b0, s, m});
  endtask
  // One timer step to count c, then the pin level is compared.
  task automatic tick(input logic s, input logic [15:0] c, input logic e);
    @(posedge clock);
    tbs[s].count <= c;
    tbs[s].inc <= 1'b1;
    @(posedge clock);
    tbs[s].inc <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmp(16'(pin), 16'(e));
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    conclude();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(78698));
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    rd(`OCC_IDX_CONTROL, 16'h0000);
    for (int n = 0; n < 4; n++) begin
      t = 1'($urandom);
      p = 16'h0001 + 16'($urandom % 16'hfffe);
      wr(`OCC_IDX_PRIMARY, p);
      ctl(3'h2, t, 1'b0);
      tick(t, p, 1'b1);
      cmp(16'(chan_flag_q), 16'h0001);
      rd(`OCC_IDX_STATUS, 16'h0001);
      wr(`OCC_IDX_STATUS, 16'h0001);
      ctl(3'h1, t, 1'b0);
      tick(!t, p, 1'b1);
      tick(t, 16'h0000, 1'b1);
      tick(t, p, 1'b0);
      ctl(3'h3, t, 1'b0);
      cpu_sleep <= 1'b1;
      tick(t, p, 1'b0);
      cpu_sleep <= 1'b0;
      tick(t, p, 1'b1);
      cpu_idle <= 1'b1;
      ctl(3'h3, t, 1'b1);
      tick(t, p, 1'b1);
      ctl(3'h3, t, 1'b0);
      tick(t, p, 1'b0);
      tbs[t].stop_idle <= 1'b1;
      tick(t, p, 1'b0);
      tbs[t].stop_idle <= 1'b0;
      cpu_idle <= 1'b0;
    end
    // Start and stop times are loaded before the mode is chosen.
    p = 16'h0001 + 16'($urandom % 16'h0064);
    q = p + 16'h0001 + 16'($urandom % 16'h0064);
    wr(`OCC_IDX_PRIMARY, p);
    wr(`OCC_IDX_SECONDARY, q);
    for (int m = 4; m < 6; m++) begin
      ctl(3'(m), 1'b0, 1'b0);
      repeat (2) begin
        tick(1'b0, 16'h0000, 1'b0);
        tick(1'b0, p, m == 5 || pulses == 0);
        tick(1'b0, q, 1'b0);
        pulses++;
      end
      pulses = 0;
    end
    ctl(3'h4, 1'b0, 1'b0);
    tick(1'b0, p, 1'b1);
    wr(`OCC_IDX_STATUS, 16'h0001);
    // The duty is written to the secondary register before the mode and the timer.
    for (int n = 0; n < 6; n++) begin
      q = n == 0 ? 16'h0000 : n == 1 ? 16'h00c9 : 16'($urandom % 200);
      wr(`OCC_IDX_SECONDARY, q);
      ctl(3'h6, 1'b0, 1'b0);
      tick(1'b0, 16'h0000, q != 16'h0000);
      want_p++;
      rd(`OCC_IDX_PRIMARY, q);
      wr(`OCC_IDX_PRIMARY, ~q);
      rd(`OCC_IDX_PRIMARY, q);
      tick(1'b0, q > 16'h00c8 ? 16'h00c8 : q, q > 16'h00c8);
      want_p += q == 16'h0000;
    end
    cmp(16'(pulses), 16'(want_p));
    rd(`OCC_IDX_STATUS, 16'h0000);
    ctl(3'h7, 1'b0, 1'b0);
    tick(1'b0, 16'h0000, q != 16'h0000);
    trip <= 1'b1;
    repeat (5) @(posedge clock);
    cmp(16'(cmp_oe_q), 16'h0000);
    rd(`OCC_IDX_CONTROL, 16'h0017);
    ctl(3'h7, 1'b0, 1'b0);
    trip <= 1'b0;
    repeat (5) @(posedge clock);
    cmp(16'(cmp_oe_q), 16'h0000);
    ctl(3'h7, 1'b0, 1'b0);
    rd(`OCC_IDX_CONTROL, 16'h0007);
    cmp(16'(cmp_oe_q), 16'h0001);
    ctl(3'h0, 1'b0, 1'b0);
    tick(1'b0, 16'h0000, 1'b1);
    cmp(16'(cmp_oe_q), 16'h0000);
    conclude();
  end
endmodule
